// [rtl/acs_cfg.svh]
// timing constants of the conversion sequencer
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH
// ******************************************************
// conversion timing
// ******************************************************
`define ACS_FIRST_RESULT_CYC   16
`define ACS_NEXT_RESULT_CYC    3
`define ACS_CLK_PERIOD_NS      100
`define ACS_FIRST_RESULT_NS    1600
`define ACS_NEXT_RESULT_NS     300
`define ACS_DONE_PULSE_MIN_NS  80
`define ACS_ACQ_MIN_NS         160
`define ACS_ACQ_MAX_NS         100000
`define ACS_SEQUENCE_DONE_PULSE_MAX_NS        250000
`endif

// [rtl/acs_pkg.sv]
// types shared by the conversion sequencer
package acs_pkg;
    typedef enum logic [1:0] {
        ACS_IDLE,
        ACS_ACQ,
        ACS_CONV
    } acs_state_t;
endpackage

// [rtl/acs_bus_port.sv]
// data bus gating: strobe combination and output enable
`timescale 1ns/1ns
`include "acs_cfg.svh"
module acs_bus_port
    import acs_pkg::*;
#(
    parameter int DW = 14
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          cs_n,
    input  wire logic          rd_n,
    input  wire logic          wr_n,
    input  wire logic [DW-1:0] result,
    input  wire logic [DW-1:0] data_in,
    output logic      [DW-1:0] data_out,
    output logic               data_oe_n,
    output logic               wr_pulse,
    output logic      [DW-1:0] wr_data
);
    // ******************************************************
    // strobe combination
    // ******************************************************
    // chip select and strobe are simply anded, no ordering needed
    wire rd_act = !cs_n && !rd_n; // RQ6
    wire wr_act = !cs_n && !wr_n; // RQ6
    logic wr_act_reg;

    // registered drive, released on the next clock edge after either strobe rises
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_out   <= '0;
            data_oe_n  <= 1'b1;
            wr_act_reg <= 1'b0;
            wr_pulse   <= 1'b0;
            wr_data    <= '0;
        end else begin
            data_out   <= result;
            data_oe_n  <= !rd_act; // RQ11
            wr_act_reg <= wr_act;
            wr_pulse   <= wr_act && !wr_act_reg; // RQ6
            if (wr_act && !wr_act_reg) begin
                wr_data <= data_in;
            end
        end
    end

    bus_drive_a: assert property (@(posedge clk) disable iff (rst) // RQ11
        !data_oe_n |-> $past(!cs_n && !rd_n))
        else $error("bus driven without select and read");
    bus_release_a: assert property (@(posedge clk) disable iff (rst) // RQ11
        (cs_n || rd_n) |=> data_oe_n)
        else $error("bus not released");
    wr_edge_a: assert property (@(posedge clk) disable iff (rst) // RQ6
        $rose(!cs_n && !wr_n) |=> wr_pulse ##1 !wr_pulse)
        else $error("write strobe not combined");
    rd_cov_c: cover property (@(posedge clk) disable iff (rst) !data_oe_n);
endmodule

// [rtl/acs_sequencer.sv]
// conversion sequencer: acquisition, result timing and done strobes
`timescale 1ns/1ns
`include "acs_cfg.svh"
// Notes on behaviour
// RQ1 - external clock: first result sixteen clocks after start rises
// RQ2 - external clock: each further result three clocks after the previous
// RQ3 - done strobe one clock per result; internal clock pulse at least 80 ns
// RQ4 - host holds start low 0.16 to 100 microseconds
// RQ5 - conversion logic acts only on rising external clock edges; with select high the code advances on every clk instead
// RQ6 - chip select anded with read and with write strobes
// RQ7 - host keeps start-fall to last-done-fall within 0.25 ms
// RQ8 - host gives first clock within 10 us of start rise, at least 100 kHz
// RQ9 - select high uses internal clock, low uses external clock
// RQ10 - last-done strobe comes with the final channel's done pulse
// RQ11 - data bus driven only while chip select and read are low; the enable is registered, so drive ends at the clock edge after either rises
module acs_sequencer
    import acs_pkg::*;
#(
    parameter int NCH = 8,
    parameter int DW  = 14
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          sample_start_n,
    input  wire logic          ext_conv_clk,
    input  wire logic          clock_source_select,
    input  wire logic          power_down_input,
    input  wire logic [NCH-1:0] channel_enable,
    input  wire logic [NCH*DW-1:0] sample_in,
    input  wire logic          cs_n,
    input  wire logic          rd_n,
    input  wire logic          wr_n,
    input  wire logic [DW-1:0] data_in,
    output logic      [DW-1:0] data_out,
    output logic               data_oe_n,
    output logic               conv_done_pulse,
    output logic               sequence_done_pulse,
    output logic               wr_pulse,
    output logic      [DW-1:0] wr_data
);
    localparam int CW = 8;
    localparam int FIRST_INT =
        (`ACS_FIRST_RESULT_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS;
    localparam int NEXT_INT =
        (`ACS_NEXT_RESULT_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS;
    localparam int PULSE_INT =
        (`ACS_DONE_PULSE_MIN_NS + `ACS_CLK_PERIOD_NS - 1) / `ACS_CLK_PERIOD_NS;

    acs_state_t     state_reg;
    acs_state_t     state_next;
    logic [CW-1:0]  cnt_reg;
    logic [NCH-1:0] pend_reg;
    logic [NCH*DW-1:0] held_reg;
    logic [DW-1:0]  result_reg;
    logic           start_d_reg;
    logic           ext_d_reg;
    logic           use_int_reg;

    // ******************************************************
    // tick selection
    // ******************************************************
    // conversion advances on internal clock or external rising edges
    wire ext_rise  = ext_conv_clk && !ext_d_reg; // RQ5
    wire tick      = use_int_reg ? 1'b1 : ext_rise; // RQ9
    wire start_up  = sample_start_n && !start_d_reg;
    wire start_dn  = !sample_start_n && start_d_reg;
    wire [CW-1:0] first_cnt = use_int_reg ? CW'(FIRST_INT) : CW'(`ACS_FIRST_RESULT_CYC);
    wire [CW-1:0] next_cnt  = use_int_reg ? CW'(NEXT_INT) : CW'(`ACS_NEXT_RESULT_CYC);
    wire [CW-1:0] pulse_cnt = use_int_reg ? CW'(PULSE_INT) : CW'(1);

    // lowest pending channel, one-hot
    wire [NCH-1:0] pick    = pend_reg & (~pend_reg + NCH'(1));
    wire [NCH-1:0] rest    = pend_reg & ~pick;
    wire           result_due = (state_reg == ACS_CONV) && tick && (cnt_reg == CW'(1));
    wire           last_due   = result_due && (rest == '0);

    logic [DW-1:0] pick_data;
    always_comb begin
        pick_data = '0;
        for (int i = 0; i < NCH; i++) begin
            if (pick[i]) begin
                pick_data = held_reg[i*DW +: DW];
            end
        end
    end

    // ******************************************************
    // sequencer
    // ******************************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ACS_IDLE: if (start_dn && !power_down_input) state_next = ACS_ACQ;
            ACS_ACQ:  if (start_up) state_next = (channel_enable == '0) ? ACS_IDLE : ACS_CONV;
            ACS_CONV: if (last_due) state_next = ACS_IDLE;
            default:  state_next = ACS_IDLE;
        endcase
    end

    // short pulse stretcher keeps done strobes at least 80 ns on internal clock
    logic [CW-1:0] pulse_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg   <= ACS_IDLE;
            start_d_reg <= 1'b1;
            ext_d_reg   <= 1'b0;
            use_int_reg <= 1'b0;
            cnt_reg     <= '0;
            pend_reg    <= '0;
            held_reg    <= '0;
            result_reg  <= '0;
        end else begin
            state_reg   <= state_next;
            start_d_reg <= sample_start_n;
            ext_d_reg   <= ext_conv_clk;
            if (state_reg == ACS_IDLE) begin
                use_int_reg <= clock_source_select; // RQ9
            end
            if (state_reg == ACS_ACQ && start_up) begin
                held_reg <= sample_in;
                pend_reg <= channel_enable;
                cnt_reg  <= first_cnt; // RQ1
            end else if (result_due) begin
                result_reg <= pick_data;
                pend_reg   <= rest;
                cnt_reg    <= next_cnt; // RQ2
            end else if (state_reg == ACS_CONV && tick) begin
                cnt_reg <= cnt_reg - CW'(1);
            end
        end
    end

    // done strobes, one per result, last one marks sequence end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pulse_reg           <= '0;
            conv_done_pulse     <= 1'b0;
            sequence_done_pulse <= 1'b0;
        end else if (result_due) begin
            pulse_reg           <= pulse_cnt - CW'(1);
            conv_done_pulse     <= 1'b1; // RQ3
            sequence_done_pulse <= last_due; // RQ10
        end else if (pulse_reg != '0) begin
            pulse_reg <= pulse_reg - CW'(1);
        end else begin
            conv_done_pulse     <= 1'b0; // RQ3
            sequence_done_pulse <= 1'b0;
        end
    end

    // ******************************************************
    // bus gating
    // ******************************************************
    // result reaches the bus with its done strobe, not one clock later
    wire [DW-1:0] result_now = result_due ? pick_data : result_reg; // RQ1 RQ2

    acs_bus_port #(.DW(DW)) u_acs_bus_port (
        .clk       (clk),
        .rst       (rst),
        .cs_n      (cs_n),
        .rd_n      (rd_n),
        .wr_n      (wr_n),
        .result    (result_now),
        .data_in   (data_in),
        .data_out  (data_out),
        .data_oe_n (data_oe_n),
        .wr_pulse  (wr_pulse),
        .wr_data   (wr_data)
    );

    // ******************************************************
    // checks
    // ******************************************************
    first_delay_a: assert property (@(posedge clk) disable iff (rst) // RQ1
        (state_reg == ACS_ACQ && start_up && !use_int_reg) |=> cnt_reg == CW'(16))
        else $error("first result delay wrong");
    next_delay_a: assert property (@(posedge clk) disable iff (rst) // RQ2
        (result_due && !last_due && !use_int_reg) |=> cnt_reg == CW'(3))
        else $error("next result delay wrong");
    ext_pulse_a: assert property (@(posedge clk) disable iff (rst) // RQ3
        (result_due && !use_int_reg) |=> conv_done_pulse ##1 !conv_done_pulse)
        else $error("done pulse not one clock");
    int_pulse_a: assert property (@(posedge clk) disable iff (rst) // RQ3
        (result_due && use_int_reg) |=> conv_done_pulse ##1 !conv_done_pulse)
        else $error("internal done pulse wrong");
    rise_only_a: assert property (@(posedge clk) disable iff (rst) // RQ5
        (state_reg == ACS_CONV && !use_int_reg && !ext_rise) |=> $stable(cnt_reg))
        else $error("count moved without rising edge");
    src_sel_a: assert property (@(posedge clk) disable iff (rst) // RQ9
        (state_reg == ACS_IDLE) |=> use_int_reg == $past(clock_source_select))
        else $error("clock source not followed");
    last_with_done_a: assert property (@(posedge clk) disable iff (rst) // RQ10
        sequence_done_pulse |-> conv_done_pulse)
        else $error("last strobe without done strobe");
    last_end_a: assert property (@(posedge clk) disable iff (rst) // RQ10
        last_due |=> sequence_done_pulse && state_reg == ACS_IDLE)
        else $error("sequence end not flagged");
    // result word and strobe pairing, channel bookkeeping
    result_data_a: assert property (@(posedge clk) disable iff (rst) // RQ1
        result_due |=> data_out == $past(pick_data))
        else $error("result word not with its strobe");
    done_source_a: assert property (@(posedge clk) disable iff (rst) // RQ3
        $rose(conv_done_pulse) |-> $past(result_due))
        else $error("done strobe without a result");
    chan_latch_a: assert property (@(posedge clk) disable iff (rst) // RQ2
        (state_reg == ACS_ACQ && start_up) |=> pend_reg == $past(channel_enable))
        else $error("channel set not latched");
    int_count_a: assert property (@(posedge clk) disable iff (rst) // RQ9
        (state_reg == ACS_CONV && use_int_reg && !result_due)
        |=> cnt_reg == $past(cnt_reg) - CW'(1))
        else $error("internal clock not counting");
    last_empty_a: assert property (@(posedge clk) disable iff (rst) // RQ10
        sequence_done_pulse |-> pend_reg == '0)
        else $error("channels left at sequence end");
    seq_cov_c: cover property (@(posedge clk) disable iff (rst) sequence_done_pulse);
    pd_cov_c: cover property (@(posedge clk) disable iff (rst)
        state_reg == ACS_IDLE && start_dn && power_down_input);
    ext_cov_c: cover property (@(posedge clk) disable iff (rst)
        result_due && !use_int_reg);
    int_cov_c: cover property (@(posedge clk) disable iff (rst)
        result_due && use_int_reg);
endmodule

// [testbench/acs_host_model.sv]
// host-side conversion clock source for the sequencer bench
`timescale 1ns/1ns
module acs_host_model #(
    parameter int HALF = 2
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic run,
    output logic      ext_conv_clk
);
    // ****************
    // clock source
    // ****************
    int cnt;
    // stands low outside frames; first rise HALF clks after run, far above 100 kHz
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 0;
            ext_conv_clk <= 1'b0;
        end else if (!run) begin
            cnt <= 0;
            ext_conv_clk <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            ext_conv_clk <= !ext_conv_clk;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// [testbench/tb_acs_sequencer.sv]
// self-checking bench for the conversion sequencer
`timescale 1ns/1ns
module tb_acs_sequencer;
    // ****************
    // signals and units
    // ****************
    logic         clk, rst, start_n, sel, pd, run, cs_n, rd_n, wr_n, ext, ext_q;
    logic         oe_n, done, sdone, wpl, dq;
    logic [7:0]   chen;
    logic [111:0] smp;
    logic [13:0]  din, dout, wdat;
    int           mismatches, comparisons, tk;

    // 100 ns clock
    always #50 clk = ~clk;

    acs_sequencer #(.NCH(8), .DW(14)) u_acs_sequencer (.clk(clk), .rst(rst),
        .sample_start_n(start_n), .ext_conv_clk(ext), .clock_source_select(sel),
        .power_down_input(pd), .channel_enable(chen), .sample_in(smp), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .data_in(din), .data_out(dout), .data_oe_n(oe_n),
        .conv_done_pulse(done), .sequence_done_pulse(sdone), .wr_pulse(wpl),
        .wr_data(wdat));
    acs_host_model #(.HALF(2)) u_acs_host_model (.clk(clk), .rst(rst), .run(run),
        .ext_conv_clk(ext));

    // ****************
    // shared tasks
    // ****************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one frame: acquire, release start, judge every result strobe by tick count
    task automatic conv(input logic mode, input logic [7:0] en);
        int k;
        int c;
        int n;
        k = 0;
        c = 0;
        dq = 1'b0;
        sel <= mode;
        chen <= en;
        @(posedge clk) start_n <= 1'b0;
        cyc(3);
        start_n <= 1'b1;
        run <= !mode;
        tk = 0;
        ext_q = 1'b0;
        for (n = 0; n < 400 && k < $countones(en); n++) begin
            @(posedge clk);
            if (mode || (ext && !ext_q)) tk++;
            ext_q = ext;
            chk(done && dq, 0);
            dq = done;
            if (done === 1'b1) begin
                while (!en[c]) c++;
                // internal start offset is not pinned to one clk, hence the window
                if (mode) chk(tk - 3 * k >= 16 && tk - 3 * k <= 18, 1);
                else chk(16'(tk), 16'(16 + 3 * k));
                chk(dout, 16'(14'h1000 + c));
                chk(sdone, (en >> (c + 1)) == 8'h00);
                c++;
                k++;
            end
        end
        if (k < $countones(en)) begin
            mismatches++;
            end_sim;
        end
        run <= 1'b0;
        cyc(2);
    endtask

    // ****************
    // scenarios
    // ****************
    // output enable follows the and of select and read; write capture likewise
    task automatic t_bus(input logic [13:0] last);
        int w;
        int n;
        w = 0;
        cs_n <= 1'b0;
        cyc(3);
        chk(oe_n, 1);
        rd_n <= 1'b0;
        cyc(3);
        chk(oe_n, 0);
        chk(dout, last);
        cs_n <= 1'b1;
        cyc(3);
        chk(oe_n, 1);
        rd_n <= 1'b1;
        wr_n <= 1'b0;
        din <= 14'h2A5;
        for (n = 0; n < 9; n++) begin
            @(posedge clk);
            if (wpl === 1'b1) w++;
            if (n == 3) cs_n <= 1'b0;
        end
        chk(16'(w), 1);
        chk(wdat, 14'h2A5);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        cyc(2);
    endtask

    // a start while powered down must give no strobe at all
    task automatic t_pd;
        int n;
        pd <= 1'b1;
        sel <= 1'b1;
        @(posedge clk) start_n <= 1'b0;
        cyc(3);
        start_n <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            chk(done, 0);
        end
        pd <= 1'b0;
    endtask

    // ****************
    // main sequence
    // ****************
    initial begin
        clk = 0;
        rst = 1;
        start_n = 1;
        sel = 0;
        pd = 0;
        run = 0;
        cs_n = 1;
        rd_n = 1;
        wr_n = 1;
        din = 0;
        chen = 0;
        ext_q = 0;
        mismatches = 0;
        comparisons = 0;
        for (int i = 0; i < 8; i++) smp[i * 14 +: 14] = 14'(14'h1000 + i);
        cyc(3);
        rst <= 1'b0;
        cyc(2);
        chk({oe_n, done, sdone, wpl}, 16'h8);
        chk(dout, 16'h0);
        conv(1'b0, 8'hA5);
        conv(1'b0, 8'h80);
        conv(1'b1, 8'h03);
        t_bus(14'h1001);
        t_pd;
        conv(1'b1, 8'hFF);
        end_sim;
    end
endmodule
